// >>> src/ptm_pkg.sv
// shared constants for the periodic timer register block
package ptm_pkg;
   // register byte addresses (one aligned word each)
   localparam logic [5:0] ADDR_RUN_CLOCK   = 6'h00;
   localparam logic [5:0] ADDR_MODE_OUTPUT = 6'h04;
   localparam logic [5:0] ADDR_CAPT_CLEAR  = 6'h08;
   localparam logic [5:0] ADDR_CNT_LOW     = 6'h0C;
   localparam logic [5:0] ADDR_CNT_HIGH    = 6'h10;
   localparam logic [5:0] ADDR_CMPA_LOW    = 6'h14;
   localparam logic [5:0] ADDR_CMPA_HIGH   = 6'h18;
   localparam logic [5:0] ADDR_CMPB_LOW    = 6'h1C;
   localparam logic [5:0] ADDR_CMPB_HIGH   = 6'h20;
   localparam logic [5:0] ADDR_PER_LOW     = 6'h24;
   localparam logic [5:0] ADDR_PER_HIGH    = 6'h28;
   // field positions
   localparam int POS_PAUSE   = 7;
   localparam int POS_CLK_HI  = 6;
   localparam int POS_RUN     = 3;
   localparam int POS_MODE_HI = 7;
   localparam int POS_PIN_HI  = 5;
   localparam int POS_LEVEL   = 3;
   localparam int POS_INVERT  = 2;
   localparam int POS_CSRC    = 1;
   localparam int POS_CCLR    = 0;
   localparam int POS_TCLR_HI = 2;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [9:0] VAL_RESET = 10'h000;
   localparam logic [9:0] CNT_MAX   = 10'h3FF;
   // clock source codes
   localparam logic [2:0] CK_SYS4  = 3'h0;
   localparam logic [2:0] CK_SYS   = 3'h1;
   localparam logic [2:0] CK_HI16  = 3'h2;
   localparam logic [2:0] CK_HI64  = 3'h3;
   localparam logic [2:0] CK_SUBA  = 3'h4;
   localparam logic [2:0] CK_SUBB  = 3'h5;
   localparam logic [2:0] CK_EXTR  = 3'h6;
   localparam logic [2:0] CK_EXTF  = 3'h7;
   localparam logic [1:0] DIV4_MAX = 2'h3;
   localparam logic [5:0] HI16_MAX = 6'h0F;
   localparam logic [5:0] HI64_MAX = 6'h3F;
   typedef enum logic [1:0] {
      PTM_MODE_COMPARE = 2'h0,
      PTM_MODE_CAPTURE = 2'h1,
      PTM_MODE_PWM     = 2'h2,
      PTM_MODE_TIMER   = 2'h3
   } ptm_mode_t;
   typedef enum logic [1:0] {
      PTM_BUS_IDLE = 2'h0,
      PTM_BUS_ACK  = 2'h1
   } ptm_bus_t;
endpackage : ptm_pkg

// >>> src/ptm_timer.sv
// periodic timer core with its register set on an Avalon-MM slave
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - pause bit freezes counter, clearing resumes
// - clock select picks one of eight sources
// - run rise zeroes and starts; fall holds
// - run rise restores output initial level
// - mode field selects four operating modes
// - compare A match drives output per field
// - pwm mode field forces or enables waveform
// - capture edges latch counter into compare A
// - clear-mode capture splits edges A and B
// - match equal to initial level: no change
// - level bit sets initial or active level
// - invert bit inverts output, not timer mode
// - trigger source: capture pin or clock pin
// - clear select (compare, timer modes): match A or P/overflow
// - capture clear field adds trigger edge clears
// - latch edge flag shows rising or falling in clear mode
// - live counter readable as two bytes
// - compare A, period, compare B are 10-bit
// - 10-bit up counter with comparators A, P
// - match, edge clears and overflow raise irq; run rise zeroing does not
module ptm_timer
   import ptm_pkg::*;
#(
   parameter int CNT_W = 10
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   // avalon-mm slave
   input  wire logic [5:0]        address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   output logic      [31:0]       readdata,
   output logic                   waitrequest,
   // internal clock ticks
   input  wire logic              hi_clk_tick,
   input  wire logic              sub_clk_tick,
   // pins
   input  wire logic              external_clock_pin,
   input  wire logic              capture_input_pin,
   output logic                   timer_out,
   output logic                   timer_irq
);
   logic [1:0]       rst_sync;
   logic             rst_n;
   logic [7:0]       run_clock_ctl;
   logic [7:0]       mode_output_ctl;
   logic [1:0]       capture_clear_sel;
   logic             latch_edge_flag;
   logic [CNT_W-1:0] counter;
   logic [CNT_W-1:0] compare_a_value;
   logic [CNT_W-1:0] compare_b_value;
   logic [CNT_W-1:0] period_value;
   logic             run_q;
   logic             ck_q;
   logic             trig_q;
   logic [1:0]       div4;
   logic [5:0]       hdiv;
   logic             out_level;
   logic             tick;
   logic             run_rise;
   logic             trig_rise;
   logic             trig_fall;
   logic             match_a;
   logic             match_p;
   logic             overflow;
   logic             clear_cnt;
   logic             cap_a;
   logic             cap_b;
   logic             wr_acc;
   logic             bus_take;
   ptm_bus_t         bus_state;
   ptm_mode_t        mode;
   logic             pause_ctl;
   logic [2:0]       clock_source_sel;
   logic             run_ctl;
   logic [1:0]       pin_function_sel;
   logic             output_level_ctl;
   logic             output_invert;
   logic             capture_source_sel;
   logic             counter_clear_sel;
   logic             trig;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   assign pause_ctl          = run_clock_ctl[POS_PAUSE];
   assign clock_source_sel   = run_clock_ctl[POS_CLK_HI -: 3];
   assign run_ctl            = run_clock_ctl[POS_RUN];
   assign mode               = ptm_mode_t'(mode_output_ctl[POS_MODE_HI -: 2]);
   assign pin_function_sel   = mode_output_ctl[POS_PIN_HI -: 2];
   assign output_level_ctl   = mode_output_ctl[POS_LEVEL];
   assign output_invert      = mode_output_ctl[POS_INVERT];
   assign capture_source_sel = mode_output_ctl[POS_CSRC];
   assign counter_clear_sel  = mode_output_ctl[POS_CCLR];

   // clock source prescalers run freely
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div4 <= 2'h0;
         hdiv <= 6'h00;
      end else begin
         div4 <= div4 + 2'h1;
         if (hi_clk_tick) begin
            hdiv <= hdiv + 6'h01;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_q  <= 1'b0;
         ck_q   <= 1'b0;
         trig_q <= 1'b0;
      end else begin
         run_q  <= run_ctl;
         ck_q   <= external_clock_pin;
         trig_q <= trig;
      end
   end

   assign trig      = capture_source_sel ? external_clock_pin : capture_input_pin;
   assign trig_rise = trig & ~trig_q;
   assign trig_fall = ~trig & trig_q;
   assign run_rise  = run_ctl & ~run_q;

   always_comb begin
      unique case (clock_source_sel)
         CK_SYS4: tick = (div4 == DIV4_MAX);
         CK_SYS:  tick = 1'b1;
         CK_HI16: tick = hi_clk_tick && (hdiv[3:0] == HI16_MAX[3:0]);
         CK_HI64: tick = hi_clk_tick && (hdiv == HI64_MAX);
         CK_SUBA: tick = sub_clk_tick;
         CK_SUBB: tick = sub_clk_tick;
         CK_EXTR: tick = external_clock_pin & ~ck_q;
         CK_EXTF: tick = ~external_clock_pin & ck_q;
      endcase
   end

   assign match_a  = (counter == compare_a_value);
   assign match_p  = (counter == period_value);
   assign overflow = (counter == CNT_MAX);

   always_comb begin
      clear_cnt = 1'b0;
      unique case (mode)
         PTM_MODE_CAPTURE: begin
            clear_cnt = match_p && (period_value != VAL_RESET);
            if (capture_clear_sel[0] && trig_rise) begin
               clear_cnt = 1'b1;
            end
            if (capture_clear_sel[1] && trig_fall) begin
               clear_cnt = 1'b1;
            end
         end
         PTM_MODE_PWM: begin
            clear_cnt = match_p && (period_value != VAL_RESET);
         end
         default: begin
            if (counter_clear_sel) begin
               clear_cnt = match_a && (compare_a_value != VAL_RESET);
            end else begin
               clear_cnt = match_p && (period_value != VAL_RESET);
            end
         end
      endcase
   end

   // capture steering
   always_comb begin
      cap_a = 1'b0;
      cap_b = 1'b0;
      if (mode == PTM_MODE_CAPTURE && run_ctl) begin
         if (capture_clear_sel == 2'h0) begin
            unique case (pin_function_sel)
               2'h0:    cap_a = trig_rise;
               2'h1:    cap_a = trig_fall;
               2'h2:    cap_a = trig_rise | trig_fall;
               default: cap_a = 1'b0;
            endcase
         end else begin
            unique case (pin_function_sel)
               2'h0: begin
                  cap_b = trig_rise;
               end
               2'h1: begin
                  cap_a = trig_fall;
               end
               2'h2: begin
                  cap_a = trig_fall;
                  cap_b = trig_rise;
               end
               default: begin
                  cap_a = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         counter <= VAL_RESET;
      end else if (run_rise) begin
         counter <= VAL_RESET;
      end else if (run_ctl && !pause_ctl && tick) begin
         if (clear_cnt) begin
            counter <= VAL_RESET;
         end else begin
            counter <= counter + 10'h001;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_irq <= 1'b0;
      end else begin
         timer_irq <= run_ctl && !pause_ctl && tick && (clear_cnt || overflow);
      end
   end

   // output level before inversion
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_level <= 1'b0;
      end else if (run_rise) begin
         out_level <= output_level_ctl;
      end else if (mode == PTM_MODE_COMPARE && run_ctl && !pause_ctl && tick && match_a
                   && compare_a_value != VAL_RESET) begin
         unique case (pin_function_sel)
            2'h1:    out_level <= 1'b0;
            2'h2:    out_level <= 1'b1;
            2'h3:    out_level <= ~out_level;
            default: out_level <= out_level;
         endcase
      end else if (mode == PTM_MODE_PWM) begin
         unique case (pin_function_sel)
            2'h0:    out_level <= ~output_level_ctl;
            2'h1:    out_level <= output_level_ctl;
            2'h2:    out_level <= (counter < compare_a_value) ? output_level_ctl
                                                              : ~output_level_ctl;
            default: out_level <= run_ctl ? output_level_ctl : ~output_level_ctl;
         endcase
      end
   end

   // timer mode leaves the pin low
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_out <= 1'b0;
      end else begin
         timer_out <= (mode == PTM_MODE_TIMER) ? 1'b0 : (out_level ^ output_invert);
      end
   end

   // avalon-mm: one wait cycle, answer on the second
   assign wr_acc   = write && !waitrequest && bus_state == PTM_BUS_ACK;
   assign bus_take = (read || write) && bus_state == PTM_BUS_IDLE;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_state   <= PTM_BUS_IDLE;
         waitrequest <= 1'b1;
      end else if (bus_take) begin
         bus_state   <= PTM_BUS_ACK;
         waitrequest <= 1'b0;
      end else begin
         bus_state   <= PTM_BUS_IDLE;
         waitrequest <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         readdata <= 32'h0000_0000;
      end else if (bus_take && read) begin
         unique case (address)
            ADDR_RUN_CLOCK:   readdata <= {24'h000000, run_clock_ctl[7:3], 3'h0};
            ADDR_MODE_OUTPUT: readdata <= {24'h000000, mode_output_ctl};
            ADDR_CAPT_CLEAR:  readdata <= {29'h0, capture_clear_sel, latch_edge_flag};
            ADDR_CNT_LOW:     readdata <= {24'h000000, counter[7:0]};
            ADDR_CNT_HIGH:    readdata <= {30'h0, counter[9:8]};
            ADDR_CMPA_LOW:    readdata <= {24'h000000, compare_a_value[7:0]};
            ADDR_CMPA_HIGH:   readdata <= {30'h0, compare_a_value[9:8]};
            ADDR_CMPB_LOW:    readdata <= {24'h000000, compare_b_value[7:0]};
            ADDR_CMPB_HIGH:   readdata <= {30'h0, compare_b_value[9:8]};
            ADDR_PER_LOW:     readdata <= {24'h000000, period_value[7:0]};
            ADDR_PER_HIGH:    readdata <= {30'h0, period_value[9:8]};
            default:          readdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_clock_ctl     <= CTL_RESET;
         mode_output_ctl   <= CTL_RESET;
         capture_clear_sel <= 2'h0;
         period_value      <= VAL_RESET;
      end else if (wr_acc) begin
         unique case (address)
            ADDR_RUN_CLOCK:   run_clock_ctl   <= {writedata[7:3], 3'h0};
            ADDR_MODE_OUTPUT: mode_output_ctl <= writedata[7:0];
            ADDR_CAPT_CLEAR:  capture_clear_sel <= writedata[POS_TCLR_HI -: 2];
            ADDR_PER_LOW:     period_value[7:0] <= writedata[7:0];
            ADDR_PER_HIGH:    period_value[9:8] <= writedata[1:0];
            default:          run_clock_ctl   <= run_clock_ctl;
         endcase
      end
   end

   // compare registers: capture wins over a software write
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         compare_a_value <= VAL_RESET;
         compare_b_value <= VAL_RESET;
         latch_edge_flag <= 1'b0;
      end else begin
         if (cap_a) begin
            compare_a_value <= counter;
         end else if (wr_acc && address == ADDR_CMPA_LOW) begin
            compare_a_value[7:0] <= writedata[7:0];
         end else if (wr_acc && address == ADDR_CMPA_HIGH) begin
            compare_a_value[9:8] <= writedata[1:0];
         end
         if (cap_b) begin
            compare_b_value <= counter;
         end else if (wr_acc && address == ADDR_CMPB_LOW) begin
            compare_b_value[7:0] <= writedata[7:0];
         end else if (wr_acc && address == ADDR_CMPB_HIGH) begin
            compare_b_value[9:8] <= writedata[1:0];
         end
         if (cap_a || cap_b) begin
            latch_edge_flag <= cap_b;
         end
      end
   end
endmodule : ptm_timer

`default_nettype wire

// >>> verification/ptm_timer_properties.sv
// port-level assertions for the periodic timer
`timescale 1ns/10ps
`default_nettype none
module ptm_timer_properties
   import ptm_pkg::*;
(
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        nrst,
   // avalon-mm slave
   input wire logic [5:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // pins
   input wire logic        timer_out,
   input wire logic        timer_irq
);
   logic [1:0] mode_sh;
   logic       run_sh, pause_sh, oc_sh, pol_sh, acc_w, acc_r;
   assign acc_w = write && !waitrequest;
   assign acc_r = read && !waitrequest;
   // shadow of the control fields as software wrote them
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         {mode_sh, run_sh, pause_sh, oc_sh, pol_sh} <= '0;
      end else if (acc_w && address == ADDR_RUN_CLOCK) begin
         run_sh   <= writedata[POS_RUN];
         pause_sh <= writedata[POS_PAUSE];
      end else if (acc_w && address == ADDR_MODE_OUTPUT) begin
         mode_sh <= writedata[7:6];
         oc_sh   <= writedata[POS_LEVEL];
         pol_sh  <= writedata[POS_INVERT];
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   property p_wait_answer;
      $rose(read) || $rose(write) |=> !waitrequest;
   endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("late answer");
   property p_wait_one;
      !waitrequest |=> waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("long accept");
   property p_cnt_high;
      acc_r && address == ADDR_CNT_HIGH |-> readdata[31:2] == 30'h0;
   endproperty
   a_cnt_high: assert property (p_cnt_high) else $error("counter high bits");
   property p_capt_unused;
      acc_r && address == ADDR_CAPT_CLEAR |-> readdata[31:3] == 29'h0;
   endproperty
   a_capt_unused: assert property (p_capt_unused) else $error("capture ctl bits");
   property p_timer_quiet;
      mode_sh == PTM_MODE_TIMER && $past(mode_sh) == PTM_MODE_TIMER |-> !timer_out;
   endproperty
   a_timer_quiet: assert property (p_timer_quiet) else $error("output in timer mode");
   property p_run_level;
      acc_w && address == ADDR_RUN_CLOCK && writedata[POS_RUN] && !run_sh
         && mode_sh == PTM_MODE_COMPARE |-> ##[1:3] timer_out == (oc_sh ^ pol_sh);
   endproperty
   a_run_level: assert property (p_run_level) else $error("initial level");
   property p_stop_quiet;
      !run_sh && !$past(run_sh) && !$past(run_sh, 2) |-> !timer_irq;
   endproperty
   a_stop_quiet: assert property (p_stop_quiet) else $error("irq while off");
   property p_pause_quiet;
      run_sh && pause_sh && $past(pause_sh, 2) && mode_sh != PTM_MODE_CAPTURE |-> !timer_irq;
   endproperty
   a_pause_quiet: assert property (p_pause_quiet) else $error("irq while paused");
endmodule : ptm_timer_properties
bind ptm_timer ptm_timer_properties u_props (.sys_clk, .nrst, .address, .read, .write,
   .writedata, .readdata, .waitrequest, .timer_out, .timer_irq);
`default_nettype wire

// >>> verification/ptm_pin_model.sv
// far-side model: tick sources and the two input pins
`timescale 1ns/10ps
`default_nettype none
module ptm_pin_model (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic nrst,
   // pulse requests
   input  wire logic ext_req,
   input  wire logic cap_req,
   // ticks and pins
   output logic      hi_clk_tick,
   output logic      sub_clk_tick,
   output logic      external_clock_pin,
   output logic      capture_input_pin
);
   logic [2:0] tk;
   logic [3:0] ec, cc;
   // one pulse per request: four cycles high, then four low
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tk <= 3'h0;
         ec <= 4'h0;
         cc <= 4'h0;
      end else begin
         tk <= tk + 3'h1;
         ec <= ext_req ? 4'h8 : (ec == 4'h0) ? 4'h0 : ec - 4'h1;
         cc <= cap_req ? 4'h8 : (cc == 4'h0) ? 4'h0 : cc - 4'h1;
      end
   end
   assign hi_clk_tick        = tk[0];
   assign sub_clk_tick       = &tk;
   assign external_clock_pin = ec > 4'h4;
   assign capture_input_pin  = cc > 4'h4;
endmodule : ptm_pin_model
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the periodic timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module testbench;
   import ptm_pkg::*;
   logic        sys_clk = 1'b0;
   logic        nrst, read, write, ext_req, cap_req, waitrequest, timer_out, timer_irq;
   logic        hi_clk_tick, sub_clk_tick, external_clock_pin, capture_input_pin, m1, m2;
   logic [5:0]  address;
   logic [31:0] writedata, readdata;
   logic [7:0]  d;
   logic [9:0]  c1, c2, c3;
   int          err_count = 0, tests_run = 0, n, lim;
   int          dv [6] = '{4, 1, 32, 128, 8, 8};
   // pwm mode bytes and the high cycles expected in a 200-cycle window
   logic [7:0]  pm [5] = '{8'hA8, 8'hA4, 8'h88, 8'h98, 8'hB8};
   int          pe [5] = '{50, 50, 0, 200, 200};
   always #5 sys_clk = ~sys_clk;
   ptm_timer dut_u (.sys_clk, .nrst, .address, .read, .write, .writedata, .readdata,
      .waitrequest, .hi_clk_tick, .sub_clk_tick, .external_clock_pin, .capture_input_pin,
      .timer_out, .timer_irq);
   ptm_pin_model model_u (.sys_clk, .nrst, .ext_req, .cap_req, .hi_clk_tick,
      .sub_clk_tick, .external_clock_pin, .capture_input_pin);
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
   endtask : tick
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      address   <= a;
      writedata <= {24'h0, v};
      write     <= 1'b1;
      do @(posedge sys_clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      address <= a;
      read    <= 1'b1;
      do @(posedge sys_clk); while (waitrequest !== 1'b0);
      v = readdata[7:0];
      read <= 1'b0;
   endtask : rd
   task automatic rdc(output logic [9:0] v);
      logic [7:0] l, h;
      rd(ADDR_CNT_LOW, l);
      rd(ADDR_CNT_HIGH, h);
      v = {h[1:0], l};
   endtask : rdc
   task automatic pulse(input bit x);
      @(posedge sys_clk);
      if (x) ext_req <= 1'b1; else cap_req <= 1'b1;
      @(posedge sys_clk);
      ext_req <= 1'b0;
      cap_req <= 1'b0;
   endtask : pulse
   task automatic cap(input logic [7:0] t, m, input bit px, input logic [5:0] ra,
                      input int ex, input logic fl);
      wr(ADDR_CMPA_LOW, 8'h00);
      wr(ADDR_CMPB_LOW, 8'h00);
      wr(ADDR_CAPT_CLEAR, t);
      wr(ADDR_MODE_OUTPUT, m);
      wr(ADDR_RUN_CLOCK, 8'h18);
      tick(100);
      pulse(px);
      tick(20);
      wr(ADDR_RUN_CLOCK, 8'h10);
      rd(ra, d);
      `CHK("capture", 1'b1, (d + 8 >= ex && d <= ex + 8))
      rdc(c1);
      rd(ADDR_CAPT_CLEAR, d);
      if (t != 8'h00) begin
         `CHK("edge flag", {t[2:1], fl}, d[2:0])
         `CHK("edge clear", 1'b1, (c1 < 10'h03C))
      end
   endtask : cap
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (50000) @(posedge sys_clk);
      err_count++;
      close_out();
   end
   initial begin
      {nrst, read, write, ext_req, cap_req, address, writedata} = '0;
      tick(6);
      nrst <= 1'b1;
      tick(3);
      for (int i = 0; i < 11; i++) begin
         rd(6'(4 * i), d);
         `CHK("reset", 8'h00, d)
      end
      for (int i = 5; i < 11; i++) begin
         wr(6'(4 * i), 8'hFF);
         rd(6'(4 * i), d);
         `CHK("value", (i % 2) ? 8'hFF : 8'h03, d)
         wr(6'(4 * i), 8'h00);
      end
      wr(ADDR_CNT_LOW, 8'hFF);
      rd(ADDR_CNT_LOW, d);
      `CHK("read only", 8'h00, d)
      wr(ADDR_RUN_CLOCK, 8'hF7);
      rd(ADDR_RUN_CLOCK, d);
      `CHK("run ctl", 8'hF0, d)
      // clear the pause and clock select bits before any mode change
      wr(ADDR_RUN_CLOCK, 8'h00);
      wr(ADDR_CAPT_CLEAR, 8'hFF);
      rd(ADDR_CAPT_CLEAR, d);
      `CHK("capture ctl", 8'h06, d)
      wr(6'h2C, 8'hFF);
      rd(6'h2C, d);
      `CHK("unmapped", 8'h00, d)
      wr(ADDR_CAPT_CLEAR, 8'h00);
      $display("register test done");
      wr(ADDR_MODE_OUTPUT, 8'hC0);
      for (int k = 0; k < 6; k++) begin
         lim = 400 / dv[k];
         wr(ADDR_RUN_CLOCK, {1'b0, 3'(k), 4'h8});
         tick(400);
         wr(ADDR_RUN_CLOCK, {1'b1, 3'(k), 4'h8});
         rdc(c1);
         tick(40);
         rdc(c2);
         `CHK("paused", c1, c2)
         // about 402 sys_clk cycles pass before the pause lands
         `CHK("rate", 1'b1, (c1 + 1 >= lim && c1 <= lim + 3))
         wr(ADDR_RUN_CLOCK, {1'b0, 3'(k), 4'h8});
         tick(40);
         wr(ADDR_RUN_CLOCK, {1'b0, 3'(k), 4'h0});
         rdc(c3);
         tick(40);
         rdc(c2);
         `CHK("held", c3, c2)
         if (k == 1) `CHK("resume", 1'b1, (c3 >= c1 + 38 && c3 <= c1 + 48))
      end
      for (int k = 6; k < 8; k++) begin
         wr(ADDR_RUN_CLOCK, {1'b0, 3'(k), 4'h8});
         repeat (5) begin
            pulse(1'b1);
            tick(10);
         end
         wr(ADDR_RUN_CLOCK, {1'b0, 3'(k), 4'h0});
         rdc(c1);
         `CHK("pin edges", 10'h005, c1)
      end
      $display("clock source test done");
      wr(ADDR_PER_LOW, 8'h0A);
      wr(ADDR_CMPA_LOW, 8'h14);
      for (int cc = 0; cc < 2; cc++) begin
         wr(ADDR_MODE_OUTPUT, {7'h60, 1'(cc)});
         wr(ADDR_RUN_CLOCK, 8'h18);
         n = 0;
         repeat (220) begin
            @(posedge sys_clk);
            n += timer_irq;
         end
         // a clear at count P gives a cycle of P+1 counts
         lim = cc ? 10 : 20;
         `CHK("clears", 1'b1, (n + 1 >= lim && n <= lim + 1))
         wr(ADDR_RUN_CLOCK, 8'h10);
      end
      wr(ADDR_PER_LOW, 8'h00);
      wr(ADDR_CMPA_LOW, 8'h64);
      for (int v = 0; v < 16; v++) begin
         wr(ADDR_MODE_OUTPUT, {2'b00, 2'(v), v[2], v[3], 2'b01});
         wr(ADDR_RUN_CLOCK, 8'h18);
         tick(10);
         `CHK("initial", v[2] ^ v[3], timer_out)
         m1 = (v[1:0] == 2'h0) ? v[2] : (v[1:0] == 2'h3) ? !v[2] : v[1];
         m2 = (v[1:0] == 2'h3) ? v[2] : m1;
         tick(140);
         `CHK("first match", m1 ^ v[3], timer_out)
         tick(80);
         `CHK("second match", m2 ^ v[3], timer_out)
         wr(ADDR_RUN_CLOCK, 8'h10);
      end
      $display("compare output test done");
      // period of 20 counts, active while the count is below 5
      wr(ADDR_PER_LOW, 8'h13);
      wr(ADDR_CMPA_LOW, 8'h05);
      for (int p = 0; p < 5; p++) begin
         wr(ADDR_MODE_OUTPUT, pm[p]);
         wr(ADDR_RUN_CLOCK, 8'h18);
         tick(20);
         n = 0;
         repeat (200) begin
            @(posedge sys_clk);
            n += timer_out;
         end
         `CHK("pwm high cycles", pe[p], n)
         wr(ADDR_RUN_CLOCK, 8'h10);
      end
      wr(ADDR_PER_LOW, 8'h00);
      $display("pwm output test done");
      cap(8'h00, 8'h40, 1'b0, ADDR_CMPA_LOW, 104, 1'b0);
      cap(8'h00, 8'h70, 1'b0, ADDR_CMPA_LOW, 0, 1'b0);
      cap(8'h02, 8'h40, 1'b0, ADDR_CMPB_LOW, 104, 1'b1);
      cap(8'h04, 8'h52, 1'b1, ADDR_CMPA_LOW, 108, 1'b0);
      cap(8'h00, 8'h42, 1'b0, ADDR_CMPA_LOW, 0, 1'b0);
      $display("capture test done");
      close_out();
   end
endmodule : testbench
`default_nettype wire
